// ===== shared/l2ba_pkg.sv
// Package: constants and carriers for the level-2 bandwidth arbiter
package l2ba_pkg;
  localparam int unsigned PRI_W = 3;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned MID_W = 4;
  localparam int unsigned NREQ = 3;
  localparam int unsigned IDX_CORE = 0;
  localparam int unsigned IDX_COPY = 1;
  localparam int unsigned IDX_SLAVE = 2;
  localparam logic [31:0] ADDR_COPY_CNT = 32'h0182_0110;
  localparam logic [31:0] ADDR_CPU_CTRL = 32'h0184_1000;
  localparam logic [31:0] ADDR_MST_PRI1 = 32'h01C1_4114;
  localparam logic [31:0] ADDR_MST_PRI2 = 32'h01C1_4118;
  localparam int unsigned CPU_PRI_LSB = 0;
  localparam int unsigned COPY_PRI_LSB = 29;
  localparam int unsigned MST_FLD_W = 4;
  localparam logic [31:0] RST_CPU_CTRL = 32'h0000_0001;
  localparam logic [31:0] RST_COPY_CNT = 32'h0000_0000;
  localparam logic [31:0] RST_MST_PRI = 32'h4444_4444;
  localparam logic [PRI_W-1:0] LVL_CMD = 3'h7;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic core;
    logic copy;
    logic slave;
  } l2ba_req_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } l2ba_cfg_s;
endpackage : l2ba_pkg

// ===== verilog/l2ba_arbiter.sv
// Level-2 RAM bandwidth arbiter between the core and the DMA requesters
`timescale 1ns/1ps
`default_nettype none
module l2ba_arbiter
  import l2ba_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire l2ba_cfg_s cfg,
  output logic [31:0] rdata,
  input wire l2ba_req_s req,
  input wire logic [MID_W-1:0] slave_mid,
  input wire logic [CNT_W-1:0] contention_threshold,
  output l2ba_req_s gnt
);

  logic [31:0] cpu_priority_ctrl;
  logic [31:0] local_copy_ch1_count;
  logic [31:0] master_priority_1;
  logic [31:0] master_priority_2;
  logic [CNT_W-1:0] cnt [NREQ];

  // Slave master field pick, used by the priority decode
  function automatic logic [PRI_W-1:0] master_field(
    input logic [63:0] words,
    input logic [MID_W-1:0] mid
  );
    int unsigned base;
    base = int'(mid) * MST_FLD_W;
    return words[base +: PRI_W];
  endfunction : master_field

  // True when a live request of priority a outranks b
  function automatic logic outranks(
    input logic live,
    input logic [PRI_W-1:0] a,
    input logic [PRI_W-1:0] b
  );
    return live && (a < b);
  endfunction : outranks

  // Register decode
  wire logic hit_cpu = cfg.addr == ADDR_CPU_CTRL;
  wire logic hit_copy = cfg.addr == ADDR_COPY_CNT;
  wire logic hit_mst1 = cfg.addr == ADDR_MST_PRI1;
  wire logic hit_mst2 = cfg.addr == ADDR_MST_PRI2;
  wire logic hit_any = hit_cpu || hit_copy || hit_mst1 || hit_mst2;
  wire logic [31:0] rd_mux =
    hit_cpu  ? cpu_priority_ctrl :
    hit_copy ? local_copy_ch1_count :
    hit_mst1 ? master_priority_1 :
    hit_mst2 ? master_priority_2 : RD_ZERO;

  // Priority sources
  wire logic [PRI_W-1:0] pri_core = cpu_priority_ctrl[CPU_PRI_LSB +: PRI_W];
  wire logic [PRI_W-1:0] pri_copy = local_copy_ch1_count[COPY_PRI_LSB +: PRI_W];
  wire logic [PRI_W-1:0] pri_slave =
    master_field({master_priority_2, master_priority_1}, slave_mid);

  // Request vector; both non-core sources count as DMA
  wire logic [NREQ-1:0] rv = {req.slave, req.copy, req.core};
  wire logic [NREQ-1:0] dma_mask = {1'b1, 1'b1, 1'b0};

  // Starvation detect
  logic [NREQ-1:0] starv;
  always_comb begin
    for (int i = 0; i < NREQ; i++) begin
      starv[i] = rv[i] && (cnt[i] >= contention_threshold);
    end
  end
  wire logic any_starv = |starv;

  // Command logic sits at level 7 and blocks the slave port while the core requests, unless the slave request is starved
  wire logic cmd_block = req.core && (pri_core == LVL_CMD);
  wire logic slave_live = req.slave && !cmd_block;

  // Priority pick; ties go to the core, then copy before slave
  wire logic win_core = req.core &&
    !outranks(req.copy, pri_copy, pri_core) &&
    !outranks(slave_live, pri_slave, pri_core);
  wire logic win_copy = req.copy && !win_core &&
    !outranks(slave_live, pri_slave, pri_copy);
  wire logic win_slave = slave_live && !win_core && !win_copy;

  // Starved requesters preempt; DMA first since the core rarely waits
  wire logic st_copy = starv[IDX_COPY];
  wire logic st_slave = starv[IDX_SLAVE] && !st_copy;
  wire logic st_core = starv[IDX_CORE] && !(|(starv & dma_mask));

  logic [NREQ-1:0] next_gnt;
  always_comb begin
    next_gnt = '0;
    if (any_starv) begin
      next_gnt[IDX_COPY] = st_copy;
      next_gnt[IDX_SLAVE] = st_slave;
      next_gnt[IDX_CORE] = st_core;
    end else begin
      next_gnt[IDX_CORE] = win_core;
      next_gnt[IDX_COPY] = win_copy;
      next_gnt[IDX_SLAVE] = win_slave;
    end
  end

  // Any live request that loses this cycle is blocked
  wire logic [NREQ-1:0] blocked = rv & ~next_gnt;

  // Register file
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_priority_ctrl <= RST_CPU_CTRL;
      local_copy_ch1_count <= RST_COPY_CNT;
      master_priority_1 <= RST_MST_PRI;
      master_priority_2 <= RST_MST_PRI;
    end else if (cfg.wr) begin
      if (hit_cpu) cpu_priority_ctrl <= cfg.wdata;
      if (hit_copy) local_copy_ch1_count <= cfg.wdata;
      if (hit_mst1) master_priority_1 <= cfg.wdata;
      if (hit_mst2) master_priority_2 <= cfg.wdata;
    end
  end

  // Read port; unmapped addresses answer zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= RD_ZERO;
    end else if (cfg.rd) begin
      rdata <= rd_mux;
    end
  end

  // Grant slice register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gnt <= '0;
    end else begin
      gnt <= {next_gnt[IDX_CORE], next_gnt[IDX_COPY], next_gnt[IDX_SLAVE]};
    end
  end

  // Contention counters saturate at the threshold so they cannot wrap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NREQ; i++) begin
        cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NREQ; i++) begin
        if (!blocked[i]) begin
          cnt[i] <= '0;
        end else if (cnt[i] < contention_threshold) begin
          cnt[i] <= cnt[i] + 1'b1;
        end
      end
    end
  end

  // Checks
  one_grant_a: assert property (@(posedge clk) disable iff (!arst_n)
    $onehot0({gnt.core, gnt.copy, gnt.slave})
  ) else $error("more than one grant in a cycle");

  grant_has_req_a: assert property (@(posedge clk) disable iff (!arst_n)
    (|rv) && !(cmd_block && rv == 3'h4) |=> (gnt.core || gnt.copy || gnt.slave)
  ) else $error("live request left without a grant");

  count_up_a: assert property (@(posedge clk) disable iff (!arst_n)
    blocked[IDX_SLAVE] && cnt[IDX_SLAVE] < contention_threshold
    |=> cnt[IDX_SLAVE] == $past(cnt[IDX_SLAVE]) + 1'b1
  ) else $error("blocked slave request did not count");

  starve_grant_a: assert property (@(posedge clk) disable iff (!arst_n)
    req.copy && cnt[IDX_COPY] >= contention_threshold |=> gnt.copy
  ) else $error("starved copy request not granted");

  starve_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
    (req.slave && !req.copy && contention_threshold == 8'h02)[*4]
    |-> gnt.slave || $past(gnt.slave) || $past(gnt.slave, 2)
  ) else $error("slave request waited past the threshold");

  tie_core_a: assert property (@(posedge clk) disable iff (!arst_n)
    req.core && req.copy && !req.slave && pri_copy == pri_core && !any_starv
    |=> gnt.core && !gnt.copy
  ) else $error("equal priority tie not given to core");

  cmd_stall_a: assert property (@(posedge clk) disable iff (!arst_n)
    req.core && pri_core == LVL_CMD && !starv[IDX_SLAVE] |=> !gnt.slave
  ) else $error("slave port passed command logic at level 7");

  cpu_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    cfg.wr && hit_cpu |=> pri_core == $past(cfg.wdata[CPU_PRI_LSB +: PRI_W])
  ) else $error("core priority not taken from its register");

  copy_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    cfg.wr && hit_copy |=> pri_copy == $past(cfg.wdata[COPY_PRI_LSB +: PRI_W])
  ) else $error("copy priority field not taken from count write");

  master_pick_a: assert property (@(posedge clk) disable iff (!arst_n)
    slave_mid == 4'h9 |-> pri_slave == master_priority_2[6:4]
  ) else $error("slave priority not from issuing master field");

  urgent_wins_a: assert property (@(posedge clk) disable iff (!arst_n)
    req.core && req.copy && !req.slave && pri_copy < pri_core && !any_starv
    |=> gnt.copy && !gnt.core
  ) else $error("more urgent copy request lost to core");

  core_over_slave_a: assert property (@(posedge clk) disable iff (!arst_n)
    req.core && req.slave && !req.copy && pri_core < pri_slave && !any_starv
    |=> gnt.core && !gnt.slave
  ) else $error("more urgent core request lost to slave port");

  grant_on_req_a: assert property (@(posedge clk) disable iff (!arst_n)
    gnt.core || gnt.copy || gnt.slave
    |-> ({gnt.core, gnt.copy, gnt.slave} & ~$past({req.core, req.copy, req.slave})) == 3'h0
  ) else $error("grant without a request in the cycle before");

  core_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    blocked[IDX_CORE] && cnt[IDX_CORE] < contention_threshold
    |=> cnt[IDX_CORE] == $past(cnt[IDX_CORE]) + 1'b1
  ) else $error("blocked core request did not count");

  copy_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    blocked[IDX_COPY] && cnt[IDX_COPY] < contention_threshold
    |=> cnt[IDX_COPY] == $past(cnt[IDX_COPY]) + 1'b1
  ) else $error("blocked copy request did not count");

  count_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    !req.copy || next_gnt[IDX_COPY] |=> cnt[IDX_COPY] == '0
  ) else $error("copy counter kept counting without contention");

  slave_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    !req.slave || next_gnt[IDX_SLAVE] |=> cnt[IDX_SLAVE] == '0
  ) else $error("slave counter kept counting without contention");

  slave_starve_a: assert property (@(posedge clk) disable iff (!arst_n)
    req.slave && cnt[IDX_SLAVE] >= contention_threshold && !starv[IDX_COPY]
    |=> gnt.slave
  ) else $error("starved slave request not granted");

  // Wait watch on the copy engine, kept apart from its contention counter
  // Restarts when the threshold moves, so each threshold is judged alone
  logic [CNT_W-1:0] thr_seen;
  logic [CNT_W:0] copy_wait;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      thr_seen <= '0;
      copy_wait <= '0;
    end else begin
      thr_seen <= contention_threshold;
      if (!req.copy || gnt.copy || thr_seen != contention_threshold) begin
        copy_wait <= '0;
      end else if (copy_wait != '1) begin
        copy_wait <= copy_wait + 1'b1;
      end
    end
  end

  copy_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
    copy_wait <= {1'b0, contention_threshold} + 1'b1
  ) else $error("copy request waited past the threshold");

  unmapped_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    cfg.wr && !hit_any
    |=> $stable(cpu_priority_ctrl) && $stable(local_copy_ch1_count)
      && $stable(master_priority_1) && $stable(master_priority_2)
  ) else $error("write to an unmapped address changed a register");

  unmapped_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    cfg.rd && !hit_any |=> rdata == RD_ZERO
  ) else $error("unmapped read did not answer zero");

  core_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    cfg.rd && hit_cpu |=> rdata == $past(cpu_priority_ctrl)
  ) else $error("core priority register read back wrong");

  copy_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    cfg.rd && hit_copy |=> rdata == $past(local_copy_ch1_count)
  ) else $error("copy count register read back wrong");

  mst_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    cfg.rd && hit_mst2 |=> rdata == $past(master_priority_2)
  ) else $error("master priority register read back wrong");

  read_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !cfg.rd |=> $stable(rdata)
  ) else $error("read data changed without a read");

  mst1_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    cfg.wr && hit_mst1 |=> master_priority_1 == $past(cfg.wdata)
  ) else $error("low master priority word not written");

  mst2_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    cfg.wr && hit_mst2 |=> master_priority_2 == $past(cfg.wdata)
  ) else $error("high master priority word not written");

endmodule : l2ba_arbiter
`default_nettype wire

// ===== sim/l2ba_requester.sv
// Requester model standing in for the core, copy engine and slave port
`timescale 1ns/1ps
`default_nettype none
module l2ba_requester
  import l2ba_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [2:0][7:0] amount,
  input wire l2ba_req_s gnt,
  output l2ba_req_s req,
  output logic [2:0][7:0] got
);
  logic [2:0][7:0] left;
  logic [2:0] g;
  logic [2:0] r;
  assign g = gnt;
  assign req = l2ba_req_s'(r);
  // Last slice drops in its grant cycle, else a spare slice is asked for
  always_comb begin
    for (int i = 0; i < 3; i++) r[i] = left[i] > {7'h0, g[i]};
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      left <= '0;
      got <= '0;
    end else if (load) begin
      left <= amount;
      got <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        left[i] <= left[i] - {7'h0, g[i]};
        got[i] <= got[i] + {7'h0, g[i]};
      end
    end
  end
endmodule : l2ba_requester
`default_nettype wire

// ===== sim/tb.sv
// Testbench for the level-2 bandwidth arbiter
`timescale 1ns/1ps
`default_nettype none
module tb;
  import l2ba_pkg::*;
  logic clk;
  logic arst_n;
  l2ba_cfg_s cfg;
  logic [31:0] rdata;
  l2ba_req_s req;
  l2ba_req_s gnt;
  logic [MID_W-1:0] mid;
  logic [CNT_W-1:0] thr;
  logic load;
  logic [2:0][7:0] amount;
  logic [2:0][7:0] got;
  int fails;
  int check_count;
  logic [31:0] adr [4] = '{ADDR_CPU_CTRL, ADDR_COPY_CNT, ADDR_MST_PRI1, ADDR_MST_PRI2};
  logic [31:0] rst [4] = '{RST_CPU_CTRL, RST_COPY_CNT, RST_MST_PRI, RST_MST_PRI};
  logic [31:0] pat [4] = '{32'h6, 32'hA000_0040, 32'h7654_3210, 32'h0123_4567};
  l2ba_arbiter dut (.clk(clk), .arst_n(arst_n), .cfg(cfg), .rdata(rdata), .req(req),
    .slave_mid(mid), .contention_threshold(thr), .gnt(gnt));
  l2ba_requester peer (.clk(clk), .arst_n(arst_n), .load(load), .amount(amount),
    .gnt(gnt), .req(req), .got(got));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // Idle edge after each access so strobes never toggle twice in one step
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    cfg = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) #1 cfg.wr = 1'b0;
    @(posedge clk) #1;
  endtask : wr
  task automatic rc(input string what, input logic [31:0] a, input logic [31:0] exp);
    cfg = '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk) #1 cfg.rd = 1'b0;
    @(posedge clk) #1 check(what, rdata, exp);
  endtask : rc
  task automatic give(input logic [7:0] c, input logic [7:0] p, input logic [7:0] s);
    amount = {c, p, s};
    load = 1'b1;
    @(posedge clk) #1 load = 1'b0;
  endtask : give
  task automatic cg(input int n, input logic [7:0] c, input logic [7:0] p, input logic [7:0] s);
    repeat (n) @(posedge clk);
    #1 check("grants", {8'h0, got}, {8'h0, c, p, s});
  endtask : cg
  initial begin
    cfg = '0;
    mid = '0;
    thr = 8'hFF;
    load = 1'b0;
    amount = '0;
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 arst_n = 1'b1;
    wr(32'h0184_1004, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) rc("reset", adr[i], rst[i]);
    rc("unmapped", 32'h0184_1004, RD_ZERO);
    for (int i = 0; i < 4; i++) begin
      wr(adr[i], pat[i]);
      rc("readback", adr[i], pat[i]);
    end
    // Distinct core and DMA levels, as software is expected to set
    wr(ADDR_CPU_CTRL, 32'h2);
    wr(ADDR_COPY_CNT, 32'h2000_0040);
    wr(ADDR_MST_PRI1, 32'h7777_7773);
    give(8'h3, 8'h3, 8'h3);
    cg(4, 8'h0, 8'h3, 8'h0);
    cg(3, 8'h3, 8'h3, 8'h0);
    cg(3, 8'h3, 8'h3, 8'h3);
    wr(ADDR_COPY_CNT, 32'h4000_0000);
    give(8'h2, 8'h2, 8'h0);
    cg(3, 8'h2, 8'h0, 8'h0);
    cg(2, 8'h2, 8'h2, 8'h0);
    wr(ADDR_CPU_CTRL, 32'h0);
    wr(ADDR_COPY_CNT, 32'hA000_0000);
    thr = 8'h04;
    give(8'h28, 8'h1, 8'h0);
    check("copy early", {24'h0, got[1]}, 32'h0);
    cg(8, 8'h06, 8'h1, 8'h0);
    wr(ADDR_CPU_CTRL, 32'h7);
    wr(ADDR_MST_PRI2, 32'h7777_7707);
    mid = 4'h9;
    thr = 8'h0A;
    give(8'h3C, 8'h0, 8'h1);
    cg(6, 8'h06, 8'h0, 8'h0);
    cg(10, 8'h0F, 8'h0, 8'h1);
    // Short threshold lets the stalled slave port through twice
    thr = 8'h02;
    give(8'h0A, 8'h0, 8'h2);
    cg(8, 8'h06, 8'h0, 8'h2);
    test_done();
  end
  // Whole sequence takes about 105 cycles; this is far beyond it
  initial begin
    #100us;
    fails++;
    test_done();
  end
endmodule : tb
`default_nettype wire
